//--- hdl/swl_pkg.sv
// Behaviour
// - Half-duplex line, one bit per slot
// - Master always opens with a command byte; swl_master issues a read slot first if rd_req_i comes first
// - Bytes travel least significant bit first
// - Master falling edge starts slot, fixed sample
// - Each slot timed alone, idle pauses fine
// - Slave gives presence pulse after connection
// - Long low is reset, presence follows release
// - Eight slots after presence form command byte
// - Master reads with a write-one style slot
// - Slave holds line low to return zero
// - Active slot at least 60 us, then recovery
// - Parties only pull low or release
package swl_pkg;
	// Clock rate in MHz
	localparam int CLK_MHZ      = 250;
	// Times in microseconds
	localparam int SLOT_US      = 60;
	localparam int RECOV_US     = 5;
	localparam int RST_US       = 480;
	localparam int RST_DET_US   = 240;
	localparam int PRES_WAIT_US = 4;
	localparam int PRES_US      = 120;
	localparam int PRES_WIN_US  = 480;
	localparam int W1_LOW_US    = 6;
	localparam int SAMPLE_US    = 15;
	localparam int HOLD0_US     = 45;
	// Cycle counts (least times round up; all integral here)
	localparam int SLOT_CYC     = SLOT_US * CLK_MHZ;
	localparam int RECOV_CYC    = RECOV_US * CLK_MHZ;
	localparam int RST_CYC      = RST_US * CLK_MHZ;
	localparam int RST_DET_CYC  = RST_DET_US * CLK_MHZ;
	localparam int PRES_WAIT_CYC = PRES_WAIT_US * CLK_MHZ;
	localparam int PRES_CYC     = PRES_US * CLK_MHZ;
	localparam int PRES_WIN_CYC = PRES_WIN_US * CLK_MHZ;
	localparam int W1_LOW_CYC   = W1_LOW_US * CLK_MHZ;
	localparam int SAMPLE_CYC   = SAMPLE_US * CLK_MHZ;
	localparam int HOLD0_CYC    = HOLD0_US * CLK_MHZ;
	// Timer and byte widths
	localparam int TW           = 18;
	localparam int BYTE_W       = 8;
	localparam int BIT_W        = 3;
	localparam logic [BIT_W-1:0] LAST_BIT = 3'h7;
endpackage

//--- hdl/swl_line_if.sv
// Shared open-drain data line with pull-up
interface swl_line_if;
	logic mst_oe;   // Master pulls low
	logic slv_oe;   // Slave pulls low
	logic line;     // Resolved level
	// Wired-AND with pull-up
	assign line = ~(mst_oe | slv_oe);
	modport master (output mst_oe, input line);
	modport slave  (output slv_oe, input line);
endinterface

//--- hdl/swl_buf2.sv
// Two-entry valid/ready buffer
module swl_buf2
	#(parameter int W = 8)
	(
	input  wire logic         clock_i,
	input  wire logic         arst_n_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
	);
	// Whole state
	typedef struct packed {
		logic [1:0][W-1:0] mem;  // Storage
		logic [1:0]        cnt;  // Fill level
		logic              rd;   // Read pointer
		logic              wr;   // Write pointer
	} swl_buf_type;
	swl_buf_type st_ff, nxt_st;
	logic push, pop;
	assign in_ready_o  = st_ff.cnt != 2'h2;
	assign out_valid_o = st_ff.cnt != 2'h0;
	assign out_data_o  = st_ff.mem[st_ff.rd];
	assign push = in_valid_i & in_ready_o;
	assign pop  = out_valid_o & out_ready_i;
	// Next state
	always_comb begin
		nxt_st = st_ff;
		if (push) begin
			nxt_st.mem[st_ff.wr] = in_data_i;
			nxt_st.wr = ~st_ff.wr;
		end
		if (pop)
			nxt_st.rd = ~st_ff.rd;
		nxt_st.cnt = st_ff.cnt + {1'b0, push} - {1'b0, pop};
	end
	// State register
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end
endmodule

//--- hdl/swl_slave.sv
// Slave end: presence, command byte, read slots
module swl_slave
	import swl_pkg::*;
	(
	input  wire logic        clock_i,
	input  wire logic        arst_n_i,
	swl_line_if.slave        bus,
	output logic [BYTE_W-1:0] cmd_data_o,
	output logic             cmd_valid_o,
	input  wire logic        cmd_ready_i,
	input  wire logic [BYTE_W-1:0] tx_data_i,
	input  wire logic        tx_valid_i,
	output logic             tx_ready_o,
	output logic             presence_o
	);
	typedef enum {S_LOW, S_WAITP, S_PRES, S_IDLE, S_SLOT} swl_sst_type;
	typedef struct packed {
		swl_sst_type       st;    // Phase
		logic [TW-1:0]     tmr;   // Slot timer
		logic [BYTE_W-1:0] sh;    // Shift register
		logic [BIT_W-1:0]  bitn;  // Bit index
		logic              cmd;   // Receiving command
		logic              oe;    // Pulling low
		logic              line_q;// Previous line level
		logic              bval;  // Byte to buffer
		logic              tx_ld; // Read byte loaded
		logic              pres;  // Presence flag
	} swl_slv_type;
	swl_slv_type st_ff, nxt_st;
	logic buf_rdy;
	logic fall;
	// Two-entry cmd buffer; a stalled consumer loses nothing until it is full
	swl_buf2 #(.W(BYTE_W)) u_buf (
		.clock_i     (clock_i),
		.arst_n_i    (arst_n_i),
		.in_valid_i  (st_ff.bval),
		.in_ready_o  (buf_rdy),
		.in_data_i   (st_ff.sh),
		.out_valid_o (cmd_valid_o),
		.out_ready_i (cmd_ready_i),
		.out_data_o  (cmd_data_o)
	);
	assign fall = st_ff.line_q & ~bus.line;
	assign bus.slv_oe = st_ff.oe;
	assign tx_ready_o = 1'b0 | (~st_ff.tx_ld & ~st_ff.cmd & (st_ff.st == S_IDLE));
	assign presence_o = st_ff.pres;
	// Next state
	always_comb begin
		nxt_st = st_ff;
		nxt_st.line_q = bus.line;
		nxt_st.tmr = st_ff.tmr + 1'b1;
		if (buf_rdy)
			nxt_st.bval = 1'b0;
		if (tx_ready_o & tx_valid_i) begin
			nxt_st.sh = tx_data_i;
			nxt_st.tx_ld = 1'b1;
			nxt_st.bitn = '0;
		end
		// long low means reset or removal
		if (!bus.line && !st_ff.oe && st_ff.tmr >= TW'(RST_DET_CYC)
		    && st_ff.st != S_LOW) begin
			nxt_st.st = S_LOW;
			nxt_st.pres = 1'b0;
		end else begin
			case (st_ff.st)
			S_LOW: begin
				// wait for line high after link
				if (bus.line) begin
					nxt_st.st = S_WAITP;
					nxt_st.tmr = '0;
				end
			end
			S_WAITP: begin
				if (st_ff.tmr >= TW'(PRES_WAIT_CYC)) begin
					nxt_st.st = S_PRES;
					nxt_st.oe = 1'b1;
					nxt_st.tmr = '0;
				end
			end
			S_PRES: begin
				if (st_ff.tmr >= TW'(PRES_CYC)) begin
					nxt_st.oe = 1'b0;
					nxt_st.st = S_IDLE;
					nxt_st.pres = 1'b1;
					nxt_st.cmd = 1'b1;
					nxt_st.tx_ld = 1'b0;
					nxt_st.bitn = '0;
				end
			end
			S_IDLE: begin
				if (fall) begin
					nxt_st.st = S_SLOT;
					nxt_st.tmr = '0;
					if (!st_ff.cmd && st_ff.tx_ld && !st_ff.sh[0])
						nxt_st.oe = 1'b1;
				end else if (!bus.line)
					nxt_st.tmr = st_ff.tmr + 1'b1;
				else
					nxt_st.tmr = '0;
			end
			S_SLOT: begin
				if (st_ff.tmr == TW'(SAMPLE_CYC) && st_ff.cmd) begin
					nxt_st.sh = {bus.line, st_ff.sh[BYTE_W-1:1]};
				end
				if (st_ff.tmr == TW'(HOLD0_CYC) && !st_ff.cmd) begin
					nxt_st.oe = 1'b0;
					nxt_st.sh = {1'b0, st_ff.sh[BYTE_W-1:1]};
				end
				// slot ends once line high again
				if (st_ff.tmr > TW'(HOLD0_CYC) && bus.line) begin
					nxt_st.st = S_IDLE;
					nxt_st.tmr = '0;
					nxt_st.bitn = st_ff.bitn + 1'b1;
					if (st_ff.bitn == LAST_BIT) begin
						if (st_ff.cmd)
							nxt_st.bval = 1'b1;
						nxt_st.cmd = 1'b0;
						nxt_st.tx_ld = 1'b0;
					end
				end
			end
			default: nxt_st.st = S_LOW;
			endcase
		end
	end
	// State register
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i)
			st_ff <= '{st: S_LOW, default: '0};
		else
			st_ff <= nxt_st;
	end
endmodule

//--- hdl/swl_master.sv
// Master end: reset, write and read slots
module swl_master
	import swl_pkg::*;
	(
	input  wire logic        clock_i,
	input  wire logic        arst_n_i,
	swl_line_if.master       bus,
	input  wire logic        rst_req_i,
	input  wire logic        wr_req_i,
	input  wire logic        rd_req_i,
	input  wire logic [BYTE_W-1:0] wr_data_i,
	output logic             busy_o,
	output logic             done_o,
	output logic [BYTE_W-1:0] rd_data_o,
	output logic             presence_o
	);
	typedef enum {M_IDLE, M_RST, M_PWIN, M_SLOT, M_REC} swl_mst_type;
	typedef struct packed {
		swl_mst_type       st;
		logic [TW-1:0]     tmr;
		logic [BYTE_W-1:0] sh;
		logic [BIT_W-1:0]  bitn;
		logic              rd;
		logic              oe;
		logic              done;
		logic              pres;
	} swl_mst_st_type;
	swl_mst_st_type st_ff, nxt_st;
	assign bus.mst_oe = st_ff.oe;
	assign busy_o     = st_ff.st != M_IDLE;
	assign done_o     = st_ff.done;
	assign rd_data_o  = st_ff.sh;
	assign presence_o = st_ff.pres;
	// Next state
	always_comb begin
		nxt_st = st_ff;
		nxt_st.done = 1'b0;
		nxt_st.tmr = st_ff.tmr + 1'b1;
		case (st_ff.st)
		M_IDLE: begin
			nxt_st.tmr = '0;
			if (rst_req_i) begin
				nxt_st.st = M_RST;
				nxt_st.oe = 1'b1;
				nxt_st.pres = 1'b0;
			end else if (wr_req_i | rd_req_i) begin
				nxt_st.st = M_SLOT;
				nxt_st.oe = 1'b1;
				nxt_st.rd = rd_req_i & ~wr_req_i;
				nxt_st.sh = rd_req_i & ~wr_req_i ? '0 : wr_data_i;
				nxt_st.bitn = '0;
			end
		end
		M_RST: begin
			if (st_ff.tmr >= TW'(RST_CYC)) begin
				nxt_st.oe = 1'b0;
				nxt_st.st = M_PWIN;
				nxt_st.tmr = '0;
			end
		end
		M_PWIN: begin
			// Presence seen inside window
			if (!bus.line && st_ff.tmr > TW'(PRES_WAIT_CYC))
				nxt_st.pres = 1'b1;
			if (st_ff.tmr >= TW'(PRES_WIN_CYC)) begin
				nxt_st.st = M_IDLE;
				nxt_st.done = 1'b1;
			end
		end
		M_SLOT: begin
			if (st_ff.tmr == TW'(W1_LOW_CYC) && (st_ff.rd || st_ff.sh[0]))
				nxt_st.oe = 1'b0;
			if (st_ff.tmr == TW'(SAMPLE_CYC) && st_ff.rd)
				nxt_st.sh = {bus.line, st_ff.sh[BYTE_W-1:1]};
			if (st_ff.tmr >= TW'(SLOT_CYC)) begin
				nxt_st.oe = 1'b0;
				nxt_st.st = M_REC;
				nxt_st.tmr = '0;
				if (!st_ff.rd)
					nxt_st.sh = {1'b0, st_ff.sh[BYTE_W-1:1]};
			end
		end
		M_REC: begin
			// next slot only after line recovers
			if (!bus.line)
				nxt_st.tmr = '0;
			else if (st_ff.tmr >= TW'(RECOV_CYC)) begin
				nxt_st.tmr = '0;
				if (st_ff.bitn == LAST_BIT) begin
					nxt_st.st = M_IDLE;
					nxt_st.done = 1'b1;
				end else begin
					nxt_st.bitn = st_ff.bitn + 1'b1;
					nxt_st.st = M_SLOT;
					nxt_st.oe = 1'b1;
				end
			end
		end
		default: nxt_st.st = M_IDLE;
		endcase
	end
	// State register
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i)
			st_ff <= '{st: M_IDLE, default: '0};
		else
			st_ff <= nxt_st;
	end
endmodule

//--- verif/swl_link_monitor.sv
// Watches the shared line between the two ends
module swl_link_monitor
	import swl_pkg::*;
	(
	input  wire logic clock_i,
	input  wire logic arst_n_i,
	input  wire logic mst_oe,
	input  wire logic slv_oe,
	input  wire logic line
	);
	logic [TW-1:0] hi_ff;  // Cycles line high
	logic [TW-1:0] lo_ff;  // Cycles master pulls
	logic [TW-1:0] slo_ff; // Cycles slave pulls
	logic [TW-1:0] sl_ff;  // Cycles since master slot start
	logic          mq_ff;  // Master enable, delayed
	logic          pend_ff; // Reset seen, presence awaited
	logic [TW-1:0] rc_ff;  // Cycles since reset release
	// Reset pulse seen ending this cycle
	wire           rst_end = !mst_oe && mq_ff && lo_ff == RST_CYC + 1;
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pend_ff <= 1'b0;
			rc_ff <= '0;
		end else if (rst_end) begin
			pend_ff <= 1'b1;
			rc_ff <= '0;
		end else if (pend_ff) begin
			pend_ff <= !slv_oe;
			rc_ff <= rc_ff + {{(TW-1){1'b0}}, ~&rc_ff};
		end
	end
	// Interval counters; hi_ff and sl_ff saturate, lo_ff and slo_ff wrap
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			hi_ff <= '0;
			lo_ff <= '0;
			slo_ff <= '0;
			sl_ff <= '1;
			mq_ff <= 1'b0;
		end else begin
			hi_ff <= line ? hi_ff + {{(TW-1){1'b0}}, ~&hi_ff} : '0;
			lo_ff <= mst_oe ? lo_ff + 1'b1 : '0;
			slo_ff <= slv_oe ? slo_ff + 1'b1 : '0;
			sl_ff <= (mst_oe && !mq_ff) ? 1'b1 :
				sl_ff + {{(TW-1){1'b0}}, ~&sl_ff};
			mq_ff <= mst_oe;
		end
	end
	default clocking @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);
	slot_length_a: assert property (
		$rose(mst_oe) |-> sl_ff >= SLOT_CYC + RECOV_CYC)
		else $error("slot started too soon");
	recovery_high_a: assert property (
		$rose(mst_oe) |-> hi_ff >= RECOV_CYC)
		else $error("no recovery before slot");
	half_duplex_a: assert property (
		$rose(mst_oe) |-> !slv_oe)
		else $error("master starts while slave pulls");
	master_low_a: assert property (
		$fell(mst_oe) |-> lo_ff == W1_LOW_CYC + 1
			|| lo_ff == SLOT_CYC + 1 || lo_ff == RST_CYC + 1)
		else $error("master low time wrong");
	presence_delay_a: assert property (
		$rose(slv_oe) && !mst_oe |-> hi_ff >= PRES_WAIT_CYC - 8
			&& hi_ff <= PRES_WAIT_CYC + 8)
		else $error("presence delay wrong");
	slave_low_a: assert property (
		$fell(slv_oe) |-> slo_ff == PRES_CYC + 1
			|| (slo_ff > SAMPLE_CYC && slo_ff <= HOLD0_CYC + 1))
		else $error("slave low time wrong");
	reset_answer_a: assert property (
		pend_ff |-> rc_ff <= 1010)
		else $error("no presence after reset");
	presence_early_a: assert property (
		$rose(slv_oe) && pend_ff |-> rc_ff >= 990)
		else $error("presence too soon after reset");
	zero_sync_a: assert property (
		$rose(slv_oe) && mst_oe |-> lo_ff <= 8)
		else $error("zero reply not synced to slot");
endmodule

//--- verif/tb.sv
// Both ends joined on one line, driven from their user sides
module tb
	import swl_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clock_i, arst_n_i;
	logic       rst_req, wr_req, rd_req, busy, done, m_pres, s_pres;
	logic       cmd_valid, cmd_ready, tx_valid, tx_ready;
	logic [7:0] wr_data, rd_data, cmd_data, tx_data, sh;
	int         errors, n_tests;
	logic       hs;
	swl_line_if line_if();
	swl_master swl_master_i(.clock_i(clock_i), .arst_n_i(arst_n_i),
		.bus(line_if), .rst_req_i(rst_req), .wr_req_i(wr_req),
		.rd_req_i(rd_req), .wr_data_i(wr_data), .busy_o(busy),
		.done_o(done), .rd_data_o(rd_data), .presence_o(m_pres));
	swl_slave swl_slave_i(.clock_i(clock_i), .arst_n_i(arst_n_i),
		.bus(line_if), .cmd_data_o(cmd_data), .cmd_valid_o(cmd_valid),
		.cmd_ready_i(cmd_ready), .tx_data_i(tx_data),
		.tx_valid_i(tx_valid), .tx_ready_o(tx_ready),
		.presence_o(s_pres));
	swl_link_monitor swl_link_monitor_i(.clock_i(clock_i),
		.arst_n_i(arst_n_i), .mst_oe(line_if.mst_oe),
		.slv_oe(line_if.slv_oe), .line(line_if.line));
	// Clock
	always #2 clock_i = ~clock_i;
	// Line level at the sample point of each slot, first bit lowest
	always begin
		@(negedge line_if.line);
		repeat (SAMPLE_CYC) @(posedge clock_i);
		sh = {line_if.line, sh[7:1]};
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One master request, then wait for its done pulse
	task op(input logic r, input logic w, input logic rd,
		input logic [7:0] d);
		int i;
		@(posedge clock_i);
		rst_req <= r;
		wr_req <= w;
		rd_req <= rd;
		wr_data <= d;
		@(posedge clock_i);
		{rst_req, wr_req, rd_req} <= 3'h0;
		for (i = 0; i < 300000 && done !== 1'b1; i++) @(negedge clock_i);
		if (done !== 1'b1) errors++;
		chk({7'h00, busy}, 8'h00);
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (1200000) @(posedge clock_i);
		errors++;
		stop_test;
	end
	// Tests
	initial begin
		clock_i = 1'b0;
		arst_n_i = 1'b0;
		{rst_req, wr_req, rd_req, cmd_ready, tx_valid} = 5'h00;
		wr_data = 8'h00;
		tx_data = 8'h00;
		errors = 0;
		n_tests = 0;
		repeat (4) @(posedge clock_i);
		arst_n_i <= 1'b1;
		repeat (PRES_WIN_CYC) @(negedge clock_i);
		chk({7'h00, s_pres}, 8'h01);
		$display("test power-up presence done");
		op(1'b1, 1'b0, 1'b0, 8'h00);
		chk({6'h00, m_pres, s_pres}, 8'h03);
		$display("test reset done");
		op(1'b0, 1'b1, 1'b0, 8'h1E);
		chk(sh, 8'h1E);
		repeat (2000) @(negedge clock_i);
		chk({cmd_valid, 7'h00}, 8'h80);
		chk(cmd_data, 8'h1E);
		@(posedge clock_i);
		cmd_ready <= 1'b1;
		tx_data <= 8'h3C;
		tx_valid <= 1'b1;
		// Hold the offer up to the edge at which ready is high
		do begin
			@(negedge clock_i);
			hs = tx_ready;
			@(posedge clock_i);
		end while (hs !== 1'b1);
		tx_valid <= 1'b0;
		@(negedge clock_i);
		chk({cmd_valid, 7'h00}, 8'h00);
		$display("test command byte done");
		op(1'b0, 1'b0, 1'b1, 8'h00);
		chk(rd_data, 8'h3C);
		chk(sh, 8'h3C);
		op(1'b0, 1'b0, 1'b1, 8'h00);
		chk(rd_data, 8'hFF);
		$display("test read bytes done");
		stop_test;
	end
endmodule
